// [rtl/chip_scrambler.sv]
// Chip scrambler: 15-bit LFSR, sixteen mask bits per step
module chip_scrambler (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Control
  input  wire logic        seed_load,
  input  wire logic        step,
  // Mask for the current symbol
  output logic [15:0]      mask
);
  import phy_mode_pkg::*;

  logic [14:0] lfsr_reg;
  logic [14:0] lfsr_next;

  always_comb begin
    lfsr_next = lfsr_reg;
    mask      = '0;
    for (int i = 0; i < 16; i++) begin
      mask[i]   = lfsr_next[14];
      lfsr_next = {lfsr_next[13:0], lfsr_next[14] ^ lfsr_next[13]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || seed_load) begin
      lfsr_reg <= SCRAM_SEED;
    end else if (step) begin
      lfsr_reg <= lfsr_next;
    end
  end
endmodule

// [rtl/phy_mode_ctrl.sv]
// Physical-layer mode selection, symbol timing and symbol packing
//
// What this block does
// RL1: BPSK chips at 300 kchip/s for 20 kb/s, 600 kchip/s for 40 kb/s.
// RL2: BPSK symbols at 20 ksymbol/s or 40 ksymbol/s matching the rate.
// RL3: Both BPSK rates use raised-cosine shaping with roll-off 1.0.
// RL4: O-QPSK runs at 400 or 1000 kchip/s as configured.
// RL5: Lower O-QPSK chip rate: half-sine plus RC-0.2, or RC-0.2 alone.
// RL6: Higher O-QPSK chip rate: half-sine, or alternatively RC-0.8.
// RL7: Standard O-QPSK gives 25 or 62.5 ksymbol/s per chip rate.
// RL8: In raised-rate modes the header goes at basic rate, PSDU raised.
// RL9: Shortened codes by two or four raise the PSDU rate accordingly.
// RL10: Host puts the transceiver idle before changing mode fields.
// RL11: Symbol periods 50, 25, 40 and 16 us by mode.
// RL12: Raised-rate modes keep the basic mode's symbol period.
// RL13: Short ack in raised-rate modes gives two or three symbols, else twelve symbols.
// RL14: Frames below a set detection threshold are not synchronised.
// RL15: Chips scrambled at 400 and 1000 kb/s unless the enable is zero.
// RL16: Automatic energy measurement in raised-rate modes lasts two symbols.
// RL17: Manual energy measurement keeps eight symbols, or two when a raised-rate automatic request comes in the same cycle.
// RL18: Raised-rate modes drop carrier sense, keep energy assessment.
// RL19: Host ignores link quality for frames in raised-rate modes.
// RL20: Mode bit 5 enables chip scrambling, reset one.
// RL21: Mode bit 4 selects the alternate spectrum, reset zero.
// RL22: Active mode derives from the fields of the mode register.
// RL23: Mode bit 3 selects BPSK at zero, O-QPSK at one; reset zero.
// RL24: Mode bit 2 selects the higher chip rate when set; reset one.
// RL25: Mode bits 1:0 select basic, 2-fold, 4-fold or alternate 500.
// RL26: Mode fields sampled while idle, held through any frame.
module phy_mode_ctrl
  import phy_mode_pkg::*;
#(
  parameter int FIFO_DEPTH    = 16,
  parameter int CYC_BPSK20    = SYM_CYC_BPSK20,
  parameter int CYC_BPSK40    = SYM_CYC_BPSK40,
  parameter int CYC_OQ400     = SYM_CYC_OQ400
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  // Register port
  input  wire logic                     reg_wr,
  input  wire logic [5:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic [7:0]                    reg_rdata,
  // Transceiver state
  input  wire logic                     trx_idle,
  // Transmit byte stream
  input  wire phy_mode_pkg::tx_byte_t   tx_in,
  input  wire logic                     tx_in_valid,
  output logic                          tx_in_ready,
  // Symbol stream to the modulator
  output phy_mode_pkg::symbol_t         sym_out,
  output logic                          sym_valid,
  output logic                          tx_done,
  // Active mode and timing
  output phy_mode_pkg::phy_cfg_t        phy_cfg,
  output logic                          sym_tick,
  output logic [3:0]                    ack_time_syms,
  // Energy measurement
  input  wire logic                     ed_auto_req,
  input  wire logic                     ed_manual_req,
  output logic                          ed_active,
  output logic                          ed_done,
  // Channel assessment and link quality
  input  wire logic [1:0]               cca_mode_in,
  output logic [1:0]                    cca_mode_out,
  output logic                          cs_available,
  output logic                          lqi_valid,
  // Receive synchronisation
  input  wire logic                     rx_sync_found,
  input  wire logic [3:0]               rx_rssi,
  output logic                          rx_sync_accept
);
  import phy_mode_pkg::*;

  localparam int TW = 14;

  if (CYC_BPSK20 < 2 || CYC_BPSK20 >= 2**TW || CYC_BPSK40 < 2 ||
      CYC_BPSK40 >= 2**TW || CYC_OQ400 < 2 || CYC_OQ400 >= 2**TW ||
      FIFO_DEPTH < 2)
    $error("phy_mode_ctrl: symbol periods must fit the timer");

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding

  function automatic phy_cfg_t decode_mode(input logic [7:0] r);
    phy_cfg_t   c;
    logic       hi;
    logic       alt;
    logic [1:0] rate;
    hi             = r[BIT_CHIP];
    alt            = r[BIT_ALT];
    rate           = r[RATE_MSB:RATE_LSB];
    c.oqpsk        = r[BIT_MOD]; // RL23
    if (!c.oqpsk) begin
      c.chip       = hi ? CHIP_600K : CHIP_300K; // RL1 RL24
      c.shape      = SHAPE_RC10; // RL3
      c.rate_fold  = FOLD_1;
      c.alt_code   = hi && alt; // RL21
    end else begin
      c.chip       = hi ? CHIP_1000K : CHIP_400K; // RL4 RL24
      if (hi) begin
        c.shape    = alt ? SHAPE_RC08 : SHAPE_SIN; // RL6 RL21
      end else begin
        c.shape    = alt ? SHAPE_RC02 : SHAPE_SIN_RC02; // RL5 RL21
      end
      if (rate == RATE_ALT500) begin
        c.rate_fold = hi ? FOLD_2 : FOLD_1; // RL25
        c.alt_code  = hi;
      end else begin
        c.rate_fold = rate; // RL9 RL25
        c.alt_code  = 1'b0;
      end
    end
    c.reserved_sel = c.oqpsk && !hi && rate == RATE_ALT500;
    c.scramble     = c.oqpsk && c.rate_fold == FOLD_4 && r[BIT_SCRAM]; // RL15 RL20
    c.hdr          = c.rate_fold != FOLD_1;
    return c;
  endfunction

  function automatic logic [TW-1:0] period_of(input phy_cfg_t c);
    logic [TW-1:0] p;
    unique case (c.chip)
      CHIP_300K:  p = TW'(CYC_BPSK20); // RL2 RL11
      CHIP_600K:  p = TW'(CYC_BPSK40); // RL2 RL11
      CHIP_400K:  p = TW'(CYC_OQ400); // RL7 RL11 RL12
      CHIP_1000K: p = TW'(SYM_CYC_OQ1000); // RL7 RL11 RL12
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] phy_mode_control_reg;
  logic [7:0] ext_mode_control_reg;
  logic [7:0] rx_sync_config_reg;
  phy_cfg_t   cfg_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phy_mode_control_reg <= PHY_MODE_RESET; // RL20 RL21 RL23 RL24
      ext_mode_control_reg <= EXT_MODE_RESET;
      rx_sync_config_reg   <= RX_SYNC_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PHY_MODE: phy_mode_control_reg <= reg_wdata;
        ADDR_EXT_MODE: ext_mode_control_reg <= reg_wdata & EXT_MODE_WMASK;
        ADDR_RX_SYNC:  rx_sync_config_reg   <= reg_wdata & RX_SYNC_WMASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        ADDR_PHY_MODE: reg_rdata <= phy_mode_control_reg;
        ADDR_EXT_MODE: reg_rdata <= ext_mode_control_reg;
        ADDR_RX_SYNC:  reg_rdata <= rx_sync_config_reg;
        default:       reg_rdata <= '0;
      endcase
    end
  end

  // Fields follow the register only while idle, so a frame never sees
  // a half-applied change even if software breaks the idle discipline
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_reg <= decode_mode(PHY_MODE_RESET);
    end else if (trx_idle) begin
      cfg_reg <= decode_mode(phy_mode_control_reg); // RL10 RL22 RL26
    end
  end
  assign phy_cfg = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Symbol timer

  logic [TW-1:0] timer_reg;
  logic          tick;

  assign tick = !trx_idle && timer_reg == '0;

  always_ff @(posedge clk_sys) begin
    if (srst || trx_idle || tick) begin
      timer_reg <= period_of(cfg_reg) - TW'(1); // RL11 RL12
    end else begin
      timer_reg <= timer_reg - TW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sym_tick <= 1'b0;
    end else begin
      sym_tick <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_HOLD = 3'b010,
    S_TX   = 3'b100
  } tx_state_t;

  tx_state_t  state_reg;
  tx_byte_t   fifo_out;
  logic       fifo_valid;
  logic       fifo_ready;
  logic [23:0] acc_reg;
  logic [4:0]  cnt_reg;
  logic [5:0]  sent_reg;
  logic        last_in_reg;
  logic [15:0] scr_mask;
  logic        header;
  logic [4:0]  k;
  logic [4:0]  n_take;
  logic [4:0]  cnt_after;
  logic        take;
  logic        finish;
  logic [15:0] sym_bits;

  stream_fifo #(
    .WIDTH ($bits(tx_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_data   (tx_in),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  chip_scrambler u_scr (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .seed_load (state_reg != S_TX),
    .step      (take && !header),
    .mask      (scr_mask)
  );

  always_comb begin
    header = sent_reg < HDR_BITS;
    if (!cfg_reg.oqpsk) begin
      k = BITS_BPSK;
    end else if (header) begin
      k = BITS_OQPSK; // RL8
    end else begin
      k = BITS_OQPSK << cfg_reg.rate_fold; // RL9
    end
    take      = state_reg == S_TX && tick &&
                (cnt_reg >= k || (last_in_reg && cnt_reg != '0));
    n_take    = (take && cnt_reg >= k) ? k : (take ? cnt_reg : '0);
    cnt_after = cnt_reg - n_take;
    finish    = take && last_in_reg && cnt_after == '0;
    // The drain stalls until the accumulator has room, so the FIFO fills
    fifo_ready = state_reg == S_TX && fifo_valid && !last_in_reg &&
                 cnt_after <= 5'h10;
    sym_bits  = acc_reg[15:0] & ~(16'hFFFF << n_take);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: state_reg <= trx_idle ? S_IDLE : S_HOLD;
        S_HOLD: begin
          if (trx_idle) begin
            state_reg <= S_IDLE;
          end else if (fifo_valid) begin
            state_reg <= S_TX;
          end
        end
        S_TX: begin
          if (trx_idle) begin
            state_reg <= S_IDLE;
          end else if (finish) begin
            state_reg <= S_HOLD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || state_reg != S_TX) begin
      acc_reg     <= '0;
      cnt_reg     <= '0;
      sent_reg    <= '0;
      last_in_reg <= 1'b0;
    end else begin
      acc_reg <= (acc_reg >> n_take) |
                 (fifo_ready ? (24'(fifo_out.data) << cnt_after) : '0);
      cnt_reg <= cnt_after + (fifo_ready ? 5'h08 : 5'h00);
      if (fifo_ready && fifo_out.last) begin
        last_in_reg <= 1'b1;
      end
      if (header) begin
        sent_reg <= sent_reg + 6'(n_take);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sym_out   <= '0;
      sym_valid <= 1'b0;
      tx_done   <= 1'b0;
    end else begin
      sym_valid <= take;
      tx_done   <= finish;
      if (take) begin
        sym_out.bits      <= (cfg_reg.scramble && !header) ?
                             (sym_bits ^ scr_mask) : sym_bits; // RL15
        sym_out.nbits     <= n_take;
        sym_out.header    <= header; // RL8
        sym_out.scrambled <= cfg_reg.scramble && !header;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode side effects

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_time_syms <= ACK_SYMS_STD;
      cs_available  <= 1'b1;
      cca_mode_out  <= '0;
      lqi_valid     <= 1'b1;
    end else begin
      if (ext_mode_control_reg[BIT_SHORT_ACK] && cfg_reg.hdr) begin
        ack_time_syms <= (cfg_reg.chip == CHIP_1000K) ?
                         ACK_SYMS_HIGH : ACK_SYMS_LOW; // RL13
      end else begin
        ack_time_syms <= ACK_SYMS_STD; // RL13
      end
      cs_available <= !cfg_reg.hdr; // RL18
      cca_mode_out <= cfg_reg.hdr ? CCA_MODE_ED : cca_mode_in; // RL18
      lqi_valid    <= !cfg_reg.hdr; // RL19
    end
  end

  logic [3:0] ed_left_reg;
  logic [3:0] ed_len_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ed_active   <= 1'b0;
      ed_done     <= 1'b0;
      ed_left_reg <= '0;
      ed_len_reg  <= '0;
    end else begin
      ed_done <= 1'b0;
      if (!ed_active && (ed_auto_req || ed_manual_req)) begin
        ed_active   <= 1'b1;
        ed_len_reg  <= (ed_auto_req && cfg_reg.hdr) ?
                       ED_SYMS_HDR : ED_SYMS_STD; // RL16 RL17
        ed_left_reg <= (ed_auto_req && cfg_reg.hdr) ?
                       ED_SYMS_HDR : ED_SYMS_STD; // RL16 RL17
      end else if (ed_active && tick) begin
        ed_left_reg <= ed_left_reg - 4'h1;
        if (ed_left_reg == 4'h1) begin
          ed_active <= 1'b0;
          ed_done   <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_sync_accept <= 1'b0;
    end else begin
      rx_sync_accept <= rx_sync_found &&
        (rx_sync_config_reg[THR_MSB:0] == '0 ||
         rx_rssi >= rx_sync_config_reg[THR_MSB:0]); // RL14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [TW-1:0] gap_reg;
  logic          tick_seen_reg;
  logic [3:0]    ed_ticks_reg;

  always_ff @(posedge clk_sys) begin
    if (srst || trx_idle) begin
      gap_reg       <= '0;
      tick_seen_reg <= 1'b0;
    end else begin
      gap_reg       <= tick ? '0 : gap_reg + TW'(1);
      tick_seen_reg <= tick_seen_reg || tick;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || !ed_active) begin
      ed_ticks_reg <= '0;
    end else if (tick) begin
      ed_ticks_reg <= ed_ticks_reg + 4'h1;
    end
  end

  a_symbol_period: assert property (@(posedge clk_sys) disable iff (srst) // RL11
    tick && tick_seen_reg |-> gap_reg == period_of(cfg_reg) - TW'(1))
    else $error("symbol period length wrong");

  a_mode_hold: assert property (@(posedge clk_sys) disable iff (srst) // RL26
    !trx_idle && $past(!trx_idle) |-> $stable(cfg_reg))
    else $error("mode changed outside idle");

  a_scram_gate: assert property (@(posedge clk_sys) disable iff (srst) // RL15
    cfg_reg.scramble |-> cfg_reg.oqpsk && cfg_reg.rate_fold == FOLD_4)
    else $error("scrambler on outside 4-fold mode");

  a_header_rate: assert property (@(posedge clk_sys) disable iff (srst) // RL8
    sym_valid && sym_out.header |-> sym_out.nbits <= BITS_OQPSK &&
    !sym_out.scrambled)
    else $error("header symbol not at basic rate");

  a_bpsk_shape: assert property (@(posedge clk_sys) disable iff (srst) // RL3
    !cfg_reg.oqpsk |-> cfg_reg.shape == SHAPE_RC10)
    else $error("BPSK shaping not RC-1.0");

  a_cs_dropped: assert property (@(posedge clk_sys) disable iff (srst) // RL18
    cfg_reg.hdr ##1 cfg_reg.hdr |-> !cs_available &&
    cca_mode_out == CCA_MODE_ED)
    else $error("carrier sense offered in raised-rate mode");

  a_ack_short: assert property (@(posedge clk_sys) disable iff (srst) // RL13
    ext_mode_control_reg[BIT_SHORT_ACK] && cfg_reg.hdr &&
    cfg_reg.chip == CHIP_1000K ##1 $stable(cfg_reg) |->
    ack_time_syms == ACK_SYMS_HIGH)
    else $error("short ack time wrong");

  a_ed_length: assert property (@(posedge clk_sys) disable iff (srst) // RL16
    ed_done |-> $past(ed_ticks_reg) + 4'h1 == ed_len_reg)
    else $error("energy measurement length wrong");

  a_rx_reject: assert property (@(posedge clk_sys) disable iff (srst) // RL14
    rx_sync_found && rx_sync_config_reg[THR_MSB:0] != '0 &&
    rx_rssi < rx_sync_config_reg[THR_MSB:0] |=> !rx_sync_accept)
    else $error("sync accepted below threshold");
endmodule

// [rtl/phy_mode_pkg.sv]
// Shared constants and types of the physical-layer mode block
package phy_mode_pkg;
  localparam int CLK_PERIOD_NS = 4;

  // Register map and reset values
  localparam logic [5:0] ADDR_PHY_MODE  = 6'h0C;
  localparam logic [5:0] ADDR_RX_SYNC   = 6'h15;
  localparam logic [5:0] ADDR_EXT_MODE  = 6'h17;
  localparam logic [7:0] PHY_MODE_RESET = 8'h24;
  localparam logic [7:0] EXT_MODE_RESET = 8'h00;
  localparam logic [7:0] RX_SYNC_RESET  = 8'h00;
  localparam logic [7:0] EXT_MODE_WMASK = 8'h76;
  localparam logic [7:0] RX_SYNC_WMASK  = 8'h0F;

  // Field positions
  localparam int BIT_SCRAM      = 5;
  localparam int BIT_ALT        = 4;
  localparam int BIT_MOD        = 3;
  localparam int BIT_CHIP       = 2;
  localparam int RATE_MSB       = 1;
  localparam int RATE_LSB       = 0;
  localparam int BIT_SHORT_ACK  = 2;
  localparam int THR_MSB        = 3;

  // PSDU rate codes and spreading folds
  localparam logic [1:0] RATE_ALT500 = 2'h3;
  localparam logic [1:0] FOLD_1      = 2'h0;
  localparam logic [1:0] FOLD_2      = 2'h1;
  localparam logic [1:0] FOLD_4      = 2'h2;

  // Symbol rates in symbol/s and the derived periods
  localparam int SYM_RATE_BPSK20 = 20000;
  localparam int SYM_RATE_BPSK40 = 40000;
  localparam int SYM_RATE_OQ400  = 25000;
  localparam int SYM_RATE_OQ1000 = 62500;
  localparam int SYM_NS_BPSK20   = 1000000000 / SYM_RATE_BPSK20;
  localparam int SYM_NS_BPSK40   = 1000000000 / SYM_RATE_BPSK40;
  localparam int SYM_NS_OQ400    = 1000000000 / SYM_RATE_OQ400;
  localparam int SYM_NS_OQ1000   = 1000000000 / SYM_RATE_OQ1000;
  localparam int SYM_CYC_BPSK20  = SYM_NS_BPSK20 / CLK_PERIOD_NS;
  localparam int SYM_CYC_BPSK40  = SYM_NS_BPSK40 / CLK_PERIOD_NS;
  localparam int SYM_CYC_OQ400   = SYM_NS_OQ400 / CLK_PERIOD_NS;
  localparam int SYM_CYC_OQ1000  = SYM_NS_OQ1000 / CLK_PERIOD_NS;

  // Counts in symbol periods
  localparam logic [3:0] ACK_SYMS_STD   = 4'hC;
  localparam logic [3:0] ACK_SYMS_LOW   = 4'h2;
  localparam logic [3:0] ACK_SYMS_HIGH  = 4'h3;
  localparam logic [3:0] ED_SYMS_STD    = 4'h8;
  localparam logic [3:0] ED_SYMS_HDR    = 4'h2;
  localparam logic [1:0] CCA_MODE_ED    = 2'h1;

  // Preamble, delimiter and length header: six bytes at basic rate
  localparam logic [5:0] HDR_BITS       = 6'h30;
  localparam logic [4:0] BITS_BPSK      = 5'h01;
  localparam logic [4:0] BITS_OQPSK     = 5'h04;
  localparam logic [14:0] SCRAM_SEED    = 15'h7FFF;

  typedef enum logic [1:0] {
    CHIP_300K, CHIP_600K, CHIP_400K, CHIP_1000K
  } chip_rate_t;

  typedef enum logic [2:0] {
    SHAPE_RC10, SHAPE_SIN_RC02, SHAPE_RC02, SHAPE_SIN, SHAPE_RC08
  } shaping_t;

  typedef struct packed {
    logic       oqpsk;
    chip_rate_t chip;
    shaping_t   shape;
    logic [1:0] rate_fold;
    logic       alt_code;
    logic       scramble;
    logic       hdr;
    logic       reserved_sel;
  } phy_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tx_byte_t;

  typedef struct packed {
    logic [15:0] bits;
    logic [4:0]  nbits;
    logic        header;
    logic        scrambled;
  } symbol_t;
endpackage

// [rtl/stream_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides
module stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    $error("stream_fifo: DEPTH must be a power of two of at least 2");

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;
  logic             in_ready_reg;
  logic [CW-1:0]    count_next;

  // Ready is a flop of its own, worked out from the next count so that
  // it never lags a pop by a cycle
  assign in_ready   = in_ready_reg;
  assign count_next = count_reg + CW'(push) - CW'(pop);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg  <= count_next;
      in_ready_reg <= (count_next != CW'(DEPTH));
    end
  end
endmodule

// [tb/phy_mode_spreading_control_tb.sv]
// Bench for the mode block: mode rows, timing, detection and a frame
module phy_mode_spreading_control_tb import phy_mode_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] v; logic q; chip_rate_t c; shaping_t s;
    logic [1:0] f; logic [3:0] a;
  } row_t;
  logic clk_sys, srst, reg_wr, trx_idle, tx_in_valid, tx_in_ready;
  logic sym_valid, tx_done, sym_tick, ed_auto_req, ed_manual_req;
  logic ed_active, ed_done, cs_available, lqi_valid, rx_sync_found;
  logic rx_sync_accept, done_seen;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, n_hdr, n_psdu, n_scr, d;
  logic [3:0] ack_time_syms, rx_rssi;
  logic [1:0] cca_mode_in, cca_mode_out;
  logic [15:0] p;
  tx_byte_t tx_in;
  symbol_t sym_out;
  phy_cfg_t phy_cfg;
  int failures = 0, checks = 0, cyc = 0;
  row_t rows[8] = '{
    '{8'h24, 1'h0, CHIP_600K, SHAPE_RC10, FOLD_1, 4'hC},
    '{8'h20, 1'h0, CHIP_300K, SHAPE_RC10, FOLD_1, 4'hC},
    '{8'h28, 1'h1, CHIP_400K, SHAPE_SIN_RC02, FOLD_1, 4'hC},
    '{8'h39, 1'h1, CHIP_400K, SHAPE_RC02, FOLD_2, 4'h2},
    '{8'h2A, 1'h1, CHIP_400K, SHAPE_SIN_RC02, FOLD_4, 4'h2},
    '{8'h2C, 1'h1, CHIP_1000K, SHAPE_SIN, FOLD_1, 4'hC},
    '{8'h3D, 1'h1, CHIP_1000K, SHAPE_RC08, FOLD_2, 4'h3},
    '{8'h0E, 1'h1, CHIP_1000K, SHAPE_SIN, FOLD_4, 4'h3}};
  phy_mode_ctrl #(.FIFO_DEPTH(16), .CYC_BPSK20(20), .CYC_BPSK40(10),
    .CYC_OQ400(16)) u_dut (.*);
  symbol_sink u_sink (.*);
  //////////////////////////////////////////
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (++cyc == 20000) begin
    failures++;
    conclude();
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'h1, a, v};
    @(negedge clk_sys) reg_wr = 0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] a);
    @(negedge clk_sys) reg_addr = a;
    @(negedge clk_sys) d = reg_rdata;
  endtask
  // Leaves p at the cycle count between two ticks
  task automatic period();
    for (int i = 0; i < 200 && sym_tick !== 1; i++) @(negedge clk_sys);
    p = 0;
    do begin @(negedge clk_sys); p++; end while (sym_tick !== 1 && p < 200);
  endtask
  task automatic ed(input logic man);
    period();
    @(negedge clk_sys) {ed_manual_req, ed_auto_req} = {man, !man};
    @(negedge clk_sys) {ed_manual_req, ed_auto_req} = 2'h0;
    p = 0;
    for (int i = 0; i < 400 && ed_done !== 1; i++) begin
      p += 16'(sym_tick === 1);
      @(negedge clk_sys);
    end
    p += 16'(sym_tick === 1);
  endtask
  initial begin
    {reg_wr, reg_addr, reg_wdata, tx_in, tx_in_valid} = '0;
    {ed_auto_req, ed_manual_req, rx_sync_found, rx_rssi} = '0;
    {srst, trx_idle, cca_mode_in} = {1'h1, 1'h1, 2'h2};
    repeat (10) @(negedge clk_sys);
    srst = 0;
    rd(ADDR_PHY_MODE);
    chk("mode reset", PHY_MODE_RESET, d);
    chk("ack reset", ACK_SYMS_STD, ack_time_syms);
    rd(6'h3F);
    chk("unmapped", 8'h00, d);
    wr(ADDR_EXT_MODE, 8'hFF);
    rd(ADDR_EXT_MODE);
    chk("ext mask", EXT_MODE_WMASK, d);
    wr(ADDR_EXT_MODE, 8'h04);
    foreach (rows[i]) begin
      wr(ADDR_PHY_MODE, rows[i].v);
      chk("cfg", {rows[i].q, rows[i].c, rows[i].s, rows[i].f},
        {phy_cfg.oqpsk, phy_cfg.chip, phy_cfg.shape, phy_cfg.rate_fold});
      chk("misc", {rows[i].a, rows[i].v[5] & (rows[i].f == FOLD_4),
        {2{rows[i].f == FOLD_1}}, rows[i].f == FOLD_1 ? 2'h2 : CCA_MODE_ED},
        {ack_time_syms, phy_cfg.scramble, cs_available, lqi_valid,
        cca_mode_out});
    end
    wr(ADDR_EXT_MODE, 8'h00);
    wr(ADDR_PHY_MODE, 8'h2B);
    chk("reserved", 16'h19, {ack_time_syms, phy_cfg.reserved_sel});
    wr(ADDR_RX_SYNC, 8'h08);
    for (int r = 7; r < 9; r++) begin
      @(negedge clk_sys) {rx_sync_found, rx_rssi} = {1'h1, 4'(r)};
      d = 0;
      repeat (2) @(negedge clk_sys)
        {d[0], rx_sync_found} = {d[0] | rx_sync_accept, 1'h0};
      chk("sync", 16'(r >= 8), d);
    end
    wr(ADDR_PHY_MODE, 8'h20);
    trx_idle = 0;
    period();
    chk("bpsk20 period", 16'd20, p);
    trx_idle = 1;
    wr(ADDR_PHY_MODE, 8'h2A);
    trx_idle = 0;
    period();
    chk("hdr period", 16'd16, p);
    wr(ADDR_PHY_MODE, 8'h2C);
    chk("frozen", CHIP_400K, phy_cfg.chip);
    wr(ADDR_PHY_MODE, 8'h2A);
    ed(0);
    chk("ed auto", ED_SYMS_HDR, p);
    ed(1);
    chk("ed manual", ED_SYMS_STD, p);
    chk("ed active", 16'h0000, ed_active);
    trx_idle = 1;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_sys) {tx_in, tx_in_valid} = {8'(i * 8'h25), i == 15, 1'h1};
      while (tx_in_ready !== 1) @(negedge clk_sys);
    end
    @(negedge clk_sys) {tx_in_valid, trx_idle} = 2'h0;
    for (int i = 0; i < 2000 && done_seen !== 1; i++) @(negedge clk_sys);
    chk("frame", {8'd12, 8'd5}, {n_hdr, n_psdu});
    chk("scrambled", 8'd5, n_scr);
    conclude();
  end
endmodule

// [tb/symbol_sink.sv]
// Modulator stand-in that tallies the symbols of one frame
module symbol_sink
  import phy_mode_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  // Symbol stream
  input  wire phy_mode_pkg::symbol_t sym_out,
  input  wire logic                  sym_valid,
  input  wire logic                  tx_done,
  // Tallies
  output logic [7:0]                 n_hdr,
  output logic [7:0]                 n_psdu,
  output logic [7:0]                 n_scr,
  output logic                       done_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////
  // Header and PSDU tallies count only well-formed units, so a wrong width shows as a short tally
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      n_hdr     <= 8'h00;
      n_psdu    <= 8'h00;
      n_scr     <= 8'h00;
      done_seen <= 1'h0;
    end else begin
      done_seen <= done_seen | tx_done;
      if (sym_valid) begin
        n_hdr  <= n_hdr + 8'(sym_out.header && sym_out.nbits == BITS_OQPSK);
        n_psdu <= n_psdu + 8'(!sym_out.header && sym_out.nbits == 5'h10);
        n_scr  <= n_scr + 8'(!sym_out.header && sym_out.scrambled);
      end
    end
  end
endmodule
